// File: hw/timer_pkg.sv
// constants shared by the timer/event counter pair
// assumes a 16-bit register address port and an 8-bit data path
package timer_pkg;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [15:0] ADDR_PORT_DIR = 16'hFF25;
  localparam logic [15:0] ADDR_PORT_LATCH = 16'hFF05;
  localparam logic [15:0] ADDR_CMP0 = 16'hFF2A;
  localparam logic [15:0] ADDR_COUNT0 = 16'hFF2B;
  localparam logic [15:0] ADDR_CLKSEL0 = 16'hFF2E;
  localparam logic [15:0] ADDR_MODE0 = 16'hFF2F;
  localparam logic [15:0] ADDR_CMP1 = 16'hFF3A;
  localparam logic [15:0] ADDR_COUNT1 = 16'hFF3B;
  localparam logic [15:0] ADDR_CLKSEL1 = 16'hFF3E;
  localparam logic [15:0] ADDR_MODE1 = 16'hFF3F;

  // ------------------------------------------------------------------
  // mode control, port direction and clock select fields
  // ------------------------------------------------------------------
  localparam int RUN_BIT = 7;
  localparam int PWM_BIT = 6;
  localparam int FORCE_HIGH_BIT = 3;
  localparam int FORCE_LOW_BIT = 2;
  localparam int LEVEL_INV_BIT = 1;
  localparam int OUT_EN_BIT = 0;
  localparam int DIR_BIT = 0;
  localparam logic [7:0] MODE0_READ_MASK = 8'hC3;
  localparam logic [7:0] MODE1_MASK = 8'hC0;
  localparam logic [7:0] CLKSEL_MASK = 8'h07;

  // ------------------------------------------------------------------
  // reset values and the pwm count top
  // ------------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;

  // ------------------------------------------------------------------
  // count clock selection: codes and prescaler shifts
  // ------------------------------------------------------------------
  localparam logic [2:0] SEL_EDGE_FALL = 3'h0;
  localparam logic [2:0] SEL_EDGE_RISE = 3'h1;
  localparam int PRESC_WIDTH = 13;
  localparam logic [3:0] T0_SHIFT [8] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hD};
  localparam logic [3:0] T1_SHIFT [8] = '{4'h0, 4'h0, 4'h1, 4'h5, 4'h7, 4'hA, 4'hD, 4'hD};

endpackage : timer_pkg

// File: hw/count_unit.sv
// one 8-bit counter with compare, match-clear and free-running pwm modes
// assumes tick is a one-cycle pulse per count clock period, on mclk
`timescale 1ns/10ps
module count_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic pwm,
  input wire logic tick,
  input wire logic [7:0] compare_value,
  // state and events
  output logic [7:0] count_value,
  output logic match_irq,
  output logic pwm_active
);

  logic [7:0] next_count;
  logic [7:0] cmp_active;
  logic [7:0] next_cmp;
  logic seen_ovf;
  logic next_seen;
  logic wrap;
  logic hit;

  assign wrap = run && tick && pwm && (count_value == timer_pkg::COUNT_TOP);
  assign hit = run && tick && !pwm && (count_value == cmp_active);

  always_comb begin
    next_count = count_value;
    if (!run) begin
      next_count = timer_pkg::ZERO_RESET;
    end else if (hit) begin
      next_count = timer_pkg::ZERO_RESET;
    end else if (tick) begin
      next_count = count_value + 8'h01;
    end
  end

  // pwm compare is buffered and only taken at overflow
  always_comb begin
    next_cmp = cmp_active;
    if (!run || !pwm || wrap) begin
      next_cmp = compare_value;
    end
    next_seen = seen_ovf;
    if (!run || !pwm) begin
      next_seen = 1'b0;
    end else if (wrap) begin
      next_seen = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= timer_pkg::ZERO_RESET;
      cmp_active <= timer_pkg::ZERO_RESET;
      seen_ovf <= 1'b0;
    end else begin
      count_value <= next_count;
      cmp_active <= next_cmp;
      seen_ovf <= next_seen;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      match_irq <= 1'b0;
      pwm_active <= 1'b0;
    end else begin
      match_irq <= hit;
      pwm_active <= run && pwm && next_seen && (next_count < next_cmp);
    end
  end

endmodule : count_unit

// File: hw/timer_event_counter.sv
// two 8-bit timer/event counters with their mode, clock and port registers
// assumes a single-cycle register port on mclk and a pad outside for the pin
`timescale 1ns/10ps

module timer_event_counter (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // shared timer pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // match requests
  output logic match_irq_t0,
  output logic match_irq_t1,
  // timer output level before the port
  output logic timer_output_pin
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] mode_control_reg_t0;
  logic [7:0] mode_control_reg_t1;
  logic [7:0] clock_select_reg_t0;
  logic [7:0] clock_select_reg_t1;
  logic [7:0] compare_value_t0;
  logic [7:0] compare_value_t1;
  logic [7:0] port_direction_reg;
  logic port_output_latch;
  logic [7:0] count_value_t0;
  logic [7:0] count_value_t1;
  logic [12:0] prescaler;
  logic event_sync1;
  logic event_sync2;
  logic event_prev;
  logic tick_t0;
  logic tick_t1;
  logic pwm_active_t0;
  logic output_ff;
  logic next_output_ff;
  logic [7:0] next_rdata;

  logic run_bit_t0;
  logic run_bit_t1;
  logic pwm_select_t0;
  logic pwm_select_t1;
  logic level_or_invert_select;
  logic output_pin_enable;
  logic pin_direction_bit;
  logic mode0_write;
  logic wr_mode1;
  logic wr_clksel0;
  logic wr_clksel1;
  logic wr_cmp0;
  logic wr_cmp1;
  logic wr_port_dir;
  logic wr_port_latch;
  logic event_rise;
  logic event_fall;

  assign run_bit_t0 = mode_control_reg_t0[timer_pkg::RUN_BIT];
  assign run_bit_t1 = mode_control_reg_t1[timer_pkg::RUN_BIT];
  assign pwm_select_t0 = mode_control_reg_t0[timer_pkg::PWM_BIT];
  assign pwm_select_t1 = mode_control_reg_t1[timer_pkg::PWM_BIT];
  assign level_or_invert_select = mode_control_reg_t0[timer_pkg::LEVEL_INV_BIT];
  assign output_pin_enable = mode_control_reg_t0[timer_pkg::OUT_EN_BIT];
  assign pin_direction_bit = port_direction_reg[timer_pkg::DIR_BIT];
  assign mode0_write = reg_wr && (reg_addr == timer_pkg::ADDR_MODE0);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // true once per 2**shift mclk cycles; shift 0 means no internal clock
  function automatic logic presc_tick(input logic [12:0] p, input logic [3:0] shift);
    logic [12:0] mask;
    mask = (13'h0001 << shift) - 13'h0001;
    return (shift != 4'h0) && ((p & mask) == mask);
  endfunction : presc_tick

  function automatic logic is_addr(input logic [15:0] a, input logic [15:0] target);
    return a == target;
  endfunction : is_addr

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  // count registers get no strobe here: they are read-only
  assign wr_mode1 = reg_wr && is_addr(reg_addr, timer_pkg::ADDR_MODE1);
  assign wr_clksel0 = reg_wr && is_addr(reg_addr, timer_pkg::ADDR_CLKSEL0);
  assign wr_clksel1 = reg_wr && is_addr(reg_addr, timer_pkg::ADDR_CLKSEL1);
  assign wr_cmp0 = reg_wr && is_addr(reg_addr, timer_pkg::ADDR_CMP0);
  assign wr_cmp1 = reg_wr && is_addr(reg_addr, timer_pkg::ADDR_CMP1);
  assign wr_port_dir = reg_wr && is_addr(reg_addr, timer_pkg::ADDR_PORT_DIR);
  assign wr_port_latch = reg_wr && is_addr(reg_addr, timer_pkg::ADDR_PORT_LATCH);

  // force bits are pulses, not storage, so they never read back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_control_reg_t0 <= timer_pkg::MODE_RESET;
    end else if (mode0_write) begin
      mode_control_reg_t0 <= reg_wdata & timer_pkg::MODE0_READ_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_control_reg_t1 <= timer_pkg::MODE_RESET;
    end else if (wr_mode1) begin
      mode_control_reg_t1 <= reg_wdata & timer_pkg::MODE1_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clock_select_reg_t0 <= timer_pkg::ZERO_RESET;
    end else if (wr_clksel0) begin
      clock_select_reg_t0 <= reg_wdata & timer_pkg::CLKSEL_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clock_select_reg_t1 <= timer_pkg::ZERO_RESET;
    end else if (wr_clksel1) begin
      clock_select_reg_t1 <= reg_wdata & timer_pkg::CLKSEL_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      compare_value_t0 <= timer_pkg::ZERO_RESET;
    end else if (wr_cmp0) begin
      compare_value_t0 <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      compare_value_t1 <= timer_pkg::ZERO_RESET;
    end else if (wr_cmp1) begin
      compare_value_t1 <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_direction_reg <= timer_pkg::PORT_DIR_RESET;
    end else if (wr_port_dir) begin
      port_direction_reg <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_output_latch <= 1'b0;
    end else if (wr_port_latch) begin
      port_output_latch <= reg_wdata[0];
    end
  end

  // ------------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      timer_pkg::ADDR_MODE0: next_rdata = mode_control_reg_t0;
      timer_pkg::ADDR_MODE1: next_rdata = mode_control_reg_t1;
      timer_pkg::ADDR_CLKSEL0: next_rdata = clock_select_reg_t0;
      timer_pkg::ADDR_CLKSEL1: next_rdata = clock_select_reg_t1;
      timer_pkg::ADDR_CMP0: next_rdata = compare_value_t0;
      timer_pkg::ADDR_CMP1: next_rdata = compare_value_t1;
      timer_pkg::ADDR_COUNT0: next_rdata = count_value_t0;
      timer_pkg::ADDR_COUNT1: next_rdata = count_value_t1;
      timer_pkg::ADDR_PORT_DIR: next_rdata = port_direction_reg;
      timer_pkg::ADDR_PORT_LATCH: next_rdata = {7'h00, port_output_latch};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // count clock generation
  // ------------------------------------------------------------------
  // one free prescaler serves both counters; start phase is not aligned
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler <= 13'h0000;
    end else begin
      prescaler <= prescaler + 13'h0001;
    end
  end

  // ------------------------------------------------------------------
  // event pin
  // ------------------------------------------------------------------
  // the pin is asynchronous; only the second stage feeds edge logic
  // all stages reset to the pull-up level so reset leaves no false edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      event_sync1 <= 1'b1;
      event_sync2 <= 1'b1;
    end else begin
      event_sync1 <= pin_in;
      event_sync2 <= event_sync1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      event_prev <= 1'b1;
    end else begin
      event_prev <= event_sync2;
    end
  end

  assign event_rise = !event_prev && event_sync2;
  assign event_fall = event_prev && !event_sync2;

  always_comb begin
    unique case (clock_select_reg_t0[2:0])
      timer_pkg::SEL_EDGE_FALL: tick_t0 = event_fall;
      timer_pkg::SEL_EDGE_RISE: tick_t0 = event_rise;
      default: tick_t0 = presc_tick(prescaler, timer_pkg::T0_SHIFT[clock_select_reg_t0[2:0]]);
    endcase
  end

  // timer 1 has no pin input; prohibited codes give no count clock
  assign tick_t1 = presc_tick(prescaler, timer_pkg::T1_SHIFT[clock_select_reg_t1[2:0]]);

  // ------------------------------------------------------------------
  // counters
  // ------------------------------------------------------------------
  count_unit unit_t0 (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run_bit_t0),
    .pwm(pwm_select_t0),
    .tick(tick_t0),
    .compare_value(compare_value_t0),
    .count_value(count_value_t0),
    .match_irq(match_irq_t0),
    .pwm_active(pwm_active_t0)
  );

  count_unit unit_t1 (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run_bit_t1),
    .pwm(pwm_select_t1),
    .tick(tick_t1),
    .compare_value(compare_value_t1),
    .count_value(count_value_t1),
    .match_irq(match_irq_t1),
    // timer 1 has no output pin, so its pwm level goes nowhere
    .pwm_active()
  );

  // ------------------------------------------------------------------
  // timer 0 output flip-flop
  // ------------------------------------------------------------------
  // a force write takes priority over a match inversion in the same cycle
  always_comb begin
    next_output_ff = output_ff;
    if (!pwm_select_t0 && match_irq_t0 && level_or_invert_select) begin
      next_output_ff = !output_ff;
    end
    if (mode0_write && !pwm_select_t0) begin
      unique case (reg_wdata[timer_pkg::FORCE_HIGH_BIT:timer_pkg::FORCE_LOW_BIT])
        2'h1: next_output_ff = 1'b0;
        2'h2: next_output_ff = 1'b1;
        default: next_output_ff = next_output_ff;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_ff <= 1'b0;
    end else begin
      output_ff <= next_output_ff;
    end
  end

  // ------------------------------------------------------------------
  // pin
  // ------------------------------------------------------------------
  // mode, level and enable act on the pin whether or not counting runs
  // in pwm mode the pin shows the inactive level until the first overflow
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_output_pin <= 1'b0;
    end else if (!output_pin_enable) begin
      timer_output_pin <= 1'b0;
    end else if (pwm_select_t0) begin
      timer_output_pin <= pwm_active_t0 ^ level_or_invert_select;
    end else begin
      timer_output_pin <= next_output_ff;
    end
  end

  // latch must be zero for the timer level to show on the pin
  assign pin_out = port_output_latch | timer_output_pin;
  assign pin_oe = !pin_direction_bit;

endmodule : timer_event_counter

// File: test/timer_event_counter_asserts.sv
// assertions on the timer pair, seeing the top module ports only
// assumes register writes are spaced by at least one idle cycle
`timescale 1ns/10ps
module timer_event_counter_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // pin and requests
  input wire logic pin_oe,
  input wire logic match_irq_t0,
  input wire logic match_irq_t1,
  input wire logic timer_output_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] mode0;
  logic [7:0] cmp0;
  logic [2:0] sel0;
  logic [9:0] gap;
  logic gap_ok;
  wire logic wr0 = reg_wr && reg_addr == timer_pkg::ADDR_MODE0;
  // shadows of stored fields: force bits act on the pwm bit held before the write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode0 <= 8'h00;
      cmp0 <= 8'h00;
      sel0 <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == timer_pkg::ADDR_MODE0) mode0 <= reg_wdata & timer_pkg::MODE0_READ_MASK;
      if (reg_addr == timer_pkg::ADDR_CMP0) cmp0 <= reg_wdata;
      if (reg_addr == timer_pkg::ADDR_CLKSEL0) sel0 <= reg_wdata[2:0];
    end
  end
  // any write may move the period, so only gaps free of writes are judged
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 10'h000;
      gap_ok <= 1'b0;
    end else begin
      gap <= match_irq_t0 ? 10'h001 : gap + 10'h001;
      gap_ok <= match_irq_t0 | (gap_ok & ~reg_wr);
    end
  end
  sequence s_stopped;
    !mode0[7] [*3];
  endsequence
  sequence s_out_off;
    wr0 && !reg_wdata[0];
  endsequence
  property p_irq_pulse;
    (match_irq_t0 |=> !match_irq_t0) and (match_irq_t1 |=> !match_irq_t1);
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("request pulse too wide");
  property p_oe_dir;
    logic d;
    (reg_wr && reg_addr == timer_pkg::ADDR_PORT_DIR, d = reg_wdata[0]) |=> pin_oe == !d;
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin drive follows direction");
  property p_out_off;
    s_out_off |-> ##2 !timer_output_pin;
  endproperty
  a_out_off: assert property (p_out_off) else $error("disabled output not low");
  property p_force;
    logic hi;
    (wr0 && !mode0[7] && !mode0[6] && !reg_wdata[7] && reg_wdata[0]
      && reg_wdata[3] != reg_wdata[2], hi = reg_wdata[3]) |-> ##2 timer_output_pin == hi;
  endproperty
  a_force: assert property (p_force) else $error("forced level not on pin");
  property p_pwm_idle;
    logic lv;
    (wr0 && mode0[6] && reg_wdata[6] && !reg_wdata[7], lv = reg_wdata[1] & reg_wdata[0])
      |-> ##3 timer_output_pin == lv;
  endproperty
  a_pwm_idle: assert property (p_pwm_idle) else $error("stopped pwm not inactive");
  property p_rd_mode0;
    reg_rd && reg_addr == timer_pkg::ADDR_MODE0 |=> reg_rdata[5:2] == 4'h0;
  endproperty
  a_rd_mode0: assert property (p_rd_mode0) else $error("force bits read nonzero");
  property p_gap;
    match_irq_t0 && gap_ok && sel0 == 3'h2 && !mode0[6] |-> gap == ({2'h0, cmp0} + 10'h001) << 1;
  endproperty
  a_gap: assert property (p_gap) else $error("match period wrong");
  property p_stopped;
    s_stopped |-> !match_irq_t0;
  endproperty
  a_stopped: assert property (p_stopped) else $error("request while stopped");
endmodule : timer_event_counter_asserts

// File: test/event_source_model.sv
// board side of the shared timer pin: a pulse source behind a pull-up
// assumes the bench sends edges only while the pin is an input
`timescale 1ns/10ps
module event_source_model (
  // clock
  input wire logic mclk,
  // pad
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  logic src_drive = 1'b0;
  logic src_val = 1'b0;
  // the pull-up holds the wire high while nobody drives it
  assign pin_level = pin_oe ? pin_out : (src_drive ? src_val : 1'b1);
  // levels held four cycles, longer than the input synchroniser needs
  task automatic send_edges(input int n);
    src_drive = 1'b1;
    for (int i = 0; i < n; i++) begin
      src_val = 1'b0;
      repeat (4) @(negedge mclk);
      src_val = 1'b1;
      repeat (4) @(negedge mclk);
    end
    src_drive = 1'b0;
  endtask : send_edges
endmodule : event_source_model

// File: test/eight_bit_timer_event_counter_control_tb.sv
// self-checking bench for the timer pair and its shared pin
// assumes the event source model stands on the pin
`timescale 1ns/10ps
module eight_bit_timer_event_counter_control_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic pin_in;
  logic pin_out;
  logic pin_oe;
  logic match_irq_t0;
  logic match_irq_t1;
  logic timer_output_pin;
  int n_fail = 0;
  int samples_checked = 0;
  int irq0_seen = 0;
  initial begin
    forever #50 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (match_irq_t0 === 1'b1) irq0_seen++;
  end
  timer_event_counter dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .match_irq_t0(match_irq_t0),
    .match_irq_t1(match_irq_t1), .timer_output_pin(timer_output_pin));
  event_source_model src_u (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_in));
  // ------------------------------------------------------------------
  // bus cycles and comparisons
  // ------------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk($sformatf("reg %h", a), 16'(reg_rdata), 16'(exp));
  endtask : rchk
  task automatic pin_is(input logic exp);
    repeat (2) @(negedge mclk);
    chk("pin", 16'(pin_out), 16'(exp));
  endtask : pin_is
  // which: 0 match t0, 1 match t1, 2 pin level
  task automatic wait_for(input int which, input logic lvl, output int cyc);
    logic s;
    cyc = 0;
    do begin
      @(negedge mclk);
      cyc++;
      s = (which == 0) ? match_irq_t0 : (which == 1) ? match_irq_t1 : pin_out;
    end while (s !== lvl && cyc < 5000);
    if (cyc >= 5000) begin
      n_fail++;
      conclude();
    end
  endtask : wait_for
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_out;
    rchk(timer_pkg::ADDR_MODE0, 8'h00);
    rchk(timer_pkg::ADDR_MODE1, 8'h00);
    rchk(timer_pkg::ADDR_PORT_DIR, 8'hFF);
    wr(timer_pkg::ADDR_PORT_LATCH, 8'h00);
    wr(timer_pkg::ADDR_PORT_DIR, 8'hFE);
    chk("pin_oe", 16'(pin_oe), 16'h0001);
    wr(timer_pkg::ADDR_MODE0, 8'h01);
    wr(timer_pkg::ADDR_MODE0, 8'h09);
    pin_is(1'b1);
    wr(timer_pkg::ADDR_MODE0, 8'h05);
    pin_is(1'b0);
    wr(timer_pkg::ADDR_MODE0, 8'h09);
    wr(timer_pkg::ADDR_MODE0, 8'h08);
    pin_is(1'b0);
  endtask : t_out
  task automatic t_interval;
    logic [7:0] sels [4] = '{8'h02, 8'h02, 8'h02, 8'h03};
    logic [7:0] cmps [4] = '{8'h00, 8'h03, 8'hFF, 8'h01};
    int c;
    int n;
    wr(timer_pkg::ADDR_MODE0, 8'h02);
    wr(timer_pkg::ADDR_MODE0, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(timer_pkg::ADDR_CLKSEL0, sels[i]);
      wr(timer_pkg::ADDR_CMP0, cmps[i]);
      wr(timer_pkg::ADDR_MODE0, 8'h0B);
      wr(timer_pkg::ADDR_MODE0, 8'h83);
      wait_for(0, 1'b1, c);
      wait_for(0, 1'b1, c);
      chk("period", 16'(c), (16'(cmps[i]) + 16'h0001) << (sels[i] - 8'h01));
      // the inversion lands one edge after the request rises
      @(negedge mclk);
      chk("inverted", 16'(pin_out), 16'h0001);
      wr(timer_pkg::ADDR_MODE0, 8'h03);
    end
    n = irq0_seen;
    repeat (20) @(negedge mclk);
    chk("stopped", 16'(irq0_seen - n), 16'h0000);
    rchk(timer_pkg::ADDR_COUNT0, 8'h00);
  endtask : t_interval
  task automatic t_pwm;
    int c;
    wr(timer_pkg::ADDR_MODE0, 8'h72);
    wr(timer_pkg::ADDR_MODE0, 8'h73);
    rchk(timer_pkg::ADDR_MODE0, 8'h43);
    pin_is(1'b1);
    wr(timer_pkg::ADDR_MODE0, 8'h47);
    rchk(timer_pkg::ADDR_MODE0, 8'h43);
    pin_is(1'b1);
    wr(timer_pkg::ADDR_MODE0, 8'h41);
    pin_is(1'b0);
    wr(timer_pkg::ADDR_CLKSEL0, 8'h02);
    wr(timer_pkg::ADDR_CMP0, 8'h80);
    wr(timer_pkg::ADDR_MODE0, 8'hC1);
    wait_for(2, 1'b1, c);
    wait_for(2, 1'b0, c);
    chk("active width", 16'(c), 16'h0100);
    wait_for(2, 1'b1, c);
    wr(timer_pkg::ADDR_MODE0, 8'h41);
    pin_is(1'b0);
    wr(timer_pkg::ADDR_MODE0, 8'h00);
  endtask : t_pwm
  task automatic t_event;
    int n;
    wr(timer_pkg::ADDR_PORT_DIR, 8'hFF);
    for (int s = 0; s < 2; s++) begin
      wr(timer_pkg::ADDR_CLKSEL0, 8'(s));
      wr(timer_pkg::ADDR_CMP0, 8'h02);
      wr(timer_pkg::ADDR_MODE0, 8'h80);
      n = irq0_seen;
      src_u.send_edges(3);
      chk("event match", 16'(irq0_seen - n), 16'h0001);
      src_u.send_edges(2);
      rchk(timer_pkg::ADDR_COUNT0, 8'h02);
      wr(timer_pkg::ADDR_MODE0, 8'h00);
    end
  endtask : t_event
  task automatic t_timer1;
    int c;
    wr(timer_pkg::ADDR_MODE1, 8'h40);
    rchk(timer_pkg::ADDR_MODE1, 8'h40);
    wr(timer_pkg::ADDR_MODE1, 8'h00);
    wr(timer_pkg::ADDR_CLKSEL1, 8'h02);
    wr(timer_pkg::ADDR_CMP1, 8'h01);
    wr(timer_pkg::ADDR_MODE1, 8'h80);
    wait_for(1, 1'b1, c);
    wait_for(1, 1'b1, c);
    chk("t1 period", 16'(c), 16'h0004);
    wr(timer_pkg::ADDR_MODE1, 8'h00);
  endtask : t_timer1
  initial begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    t_out();
    t_interval();
    t_pwm();
    t_event();
    t_timer1();
    conclude();
  end
endmodule : eight_bit_timer_event_counter_control_tb
bind timer_event_counter timer_event_counter_asserts chk_u (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .pin_oe(pin_oe), .match_irq_t0(match_irq_t0),
  .match_irq_t1(match_irq_t1), .timer_output_pin(timer_output_pin));
